// File: hdl/cpwm_map.vh
// register offsets, field positions, reset values and timing counts for the complementary pwm timer
`ifndef CPWM_MAP_VH
`define CPWM_MAP_VH
`define CPWM_OFS_CH3_CTRL     8'h00
`define CPWM_OFS_CH4_CTRL     8'h04
`define CPWM_OFS_CH3_MODE     8'h08
`define CPWM_OFS_OUT_CTRL     8'h0c
`define CPWM_OFS_START        8'h10
`define CPWM_OFS_STANDBY      8'h14
`define CPWM_OFS_CH3_CNT      8'h18
`define CPWM_OFS_CH4_CNT      8'h1c
`define CPWM_OFS_CH3_PER_CMP  8'h20
`define CPWM_OFS_CH3_DUTY_CMP 8'h24
`define CPWM_OFS_CH3_PER_BUF  8'h28
`define CPWM_OFS_CH3_DUTY_BUF 8'h2c
`define CPWM_OFS_CH4_CMP_A    8'h30
`define CPWM_OFS_CH4_CMP_B    8'h34
`define CPWM_OFS_CH4_BUF_A    8'h38
`define CPWM_OFS_CH4_BUF_B    8'h3c
`define CPWM_OFS_DEAD         8'h40
`define CPWM_OFS_CYCLE        8'h44
`define CPWM_OFS_CYCLE_BUF    8'h48
`define CPWM_OFS_STATUS       8'h4c
`define CPWM_CLR_LSB          5
`define CPWM_EDGE_LSB         3
`define CPWM_PSC_LSB          0
`define CPWM_CLR_NONE         3'h0
`define CPWM_EDGE_RISE        2'h0
`define CPWM_PSC_DIV4         3'h1
`define CPWM_PSC_DIV1         3'h0
`define CPWM_MODE_CPWM3       4'hf
`define CPWM_BIT_SYNC_EN      6
`define CPWM_BIT_LOCK         3
`define CPWM_BIT_SRC          2
`define CPWM_BIT_LVL_N        1
`define CPWM_BIT_LVL_P        0
`define CPWM_BIT_MSTOP        22
`define CPWM_RST_CTRL         8'h00
`define CPWM_RST_STANDBY      32'h0040_0000
`define CPWM_DIV4_COUNT       2'h3
`endif

// File: hdl/cpwm_prescale.v
// prescaler: makes the count tick from control fields
`timescale 1ns/1ps
module cpwm_prescale
(
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire       run_i,
  input  wire [7:0] ctrl_i,
  output reg        tick_o
);
`include "cpwm_map.vh"
  reg  [1:0] div_cnt;
  wire [2:0] psc  = ctrl_i[`CPWM_PSC_LSB+2:`CPWM_PSC_LSB];
  wire [1:0] edge_sel = ctrl_i[`CPWM_EDGE_LSB+1:`CPWM_EDGE_LSB];
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !run_i)
    begin
      div_cnt <= 2'h0;
      tick_o  <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 2'h1;
      if (edge_sel != `CPWM_EDGE_RISE)
        tick_o <= 1'b0;
      else if (psc == `CPWM_PSC_DIV4)
        tick_o <= (div_cnt == `CPWM_DIV4_COUNT);
      else
        tick_o <= (psc == `CPWM_PSC_DIV1);
    end
  end
endmodule // cpwm_prescale

// File: hdl/cpwm_phase.v
// one complementary phase output pair
`timescale 1ns/1ps
module cpwm_phase
(
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        active_i,
  input  wire [15:0] cnt3_i,
  input  wire [15:0] cnt4_i,
  input  wire [15:0] cmp_i,
  input  wire [15:0] dead_i,
  input  wire        lvl_p_i,
  input  wire        lvl_n_i,
  output reg         pos_o,
  output reg         neg_o
);
  // positive on when ch3 counter at or below compare; negative off until ch4 passes it
  wire pos_on = (cnt3_i <= cmp_i);
  wire neg_on = (cnt4_i > cmp_i) || (cmp_i < dead_i && cnt4_i > cmp_i);
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !active_i)
    begin
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end
    else
    begin
      pos_o <= lvl_p_i ? pos_on : ~pos_on;
      neg_o <= lvl_n_i ? (neg_on & ~pos_on) : ~(neg_on & ~pos_on);
    end
  end
endmodule // cpwm_phase

// File: hdl/cpwm_timer.v
// complementary pwm timer pair with avalon-mm register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module cpwm_timer
(
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  output reg         ch3_sync_toggle_output_o,
  output reg         phase_u_positive_output_o,
  output reg         phase_u_negative_output_o,
  output reg         phase_v_positive_output_o,
  output reg         phase_v_negative_output_o,
  output reg         phase_w_positive_output_o,
  output reg         phase_w_negative_output_o
);
`include "cpwm_map.vh"
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]  ch3_timer_control;
  reg  [7:0]  ch4_timer_control;
  reg  [7:0]  ch3_mode;
  reg  [7:0]  output_control_one;
  reg  [1:0]  start_bits;
  reg  [31:0] standby_control_four;
  reg  [15:0] ch3_counter;
  reg  [15:0] ch4_counter;
  reg  [15:0] ch3_period_compare;
  reg  [15:0] ch3_duty_compare;
  reg  [15:0] ch3_period_buffer;
  reg  [15:0] ch3_duty_buffer;
  reg  [15:0] ch4_duty_compare_first;
  reg  [15:0] ch4_duty_compare_second;
  reg  [15:0] ch4_duty_buffer_first;
  reg  [15:0] ch4_duty_buffer_second;
  reg  [15:0] dead_time_value;
  reg  [15:0] half_carrier_cycle;
  reg  [15:0] half_carrier_cycle_buffer;
  reg  [15:0] stage_period;
  reg  [15:0] stage_duty3;
  reg  [15:0] stage_duty4a;
  reg  [15:0] stage_duty4b;
  reg  [15:0] stage_cycle;
  reg         ch3_down;
  reg         ch4_down;
  reg         ack;
  reg  [31:0] next_readdata;
  wire        timer_clk_en;
  wire        cpwm_mode;
  wire        run3;
  wire        run4;
  wire        tick3;
  wire        tick4;
  wire        wr;
  wire        crest;
  wire        trough;
  wire [31:0] wdata;
  wire        pu_p;
  wire        pu_n;
  wire        pv_p;
  wire        pv_n;
  wire        pw_p;
  wire        pw_n;

  assign timer_clk_en = ~standby_control_four[`CPWM_BIT_MSTOP];
  assign cpwm_mode    = (ch3_mode[3:0] == `CPWM_MODE_CPWM3);
  assign run3         = timer_clk_en & start_bits[0];
  assign run4         = timer_clk_en & start_bits[1];
  assign wr           = avs_write_i & ack;
  assign wdata        = avs_writedata_i;
  assign crest        = tick3 & ~ch3_down & (ch3_counter == ch3_period_compare);
  assign trough       = tick4 & ch4_down & (ch4_counter == 16'h0000);

  // ----------------------------------------
  // count clocks
  // ----------------------------------------
  cpwm_prescale u_psc3
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (run3),
    .ctrl_i    (ch3_timer_control),
    .tick_o    (tick3)
  );
  cpwm_prescale u_psc4
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (run4),
    .ctrl_i    (ch4_timer_control),
    .tick_o    (tick4)
  );

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      ack <= 1'b0;
    else
      ack <= (avs_read_i | avs_write_i) & ~ack;
  end

  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack);
  end

  always @*
  begin
    next_readdata = 32'h0000_0000;
    if (avs_address_i == `CPWM_OFS_CH3_CTRL)
      next_readdata = {24'h0, ch3_timer_control};
    else if (avs_address_i == `CPWM_OFS_CH4_CTRL)
      next_readdata = {24'h0, ch4_timer_control};
    else if (avs_address_i == `CPWM_OFS_CH3_MODE)
      next_readdata = {24'h0, ch3_mode};
    else if (avs_address_i == `CPWM_OFS_OUT_CTRL)
      next_readdata = {24'h0, output_control_one};
    else if (avs_address_i == `CPWM_OFS_START)
      next_readdata = {30'h0, start_bits};
    else if (avs_address_i == `CPWM_OFS_STANDBY)
      next_readdata = standby_control_four;
    else if (avs_address_i == `CPWM_OFS_CH3_CNT)
      next_readdata = {16'h0, ch3_counter};
    else if (avs_address_i == `CPWM_OFS_CH4_CNT)
      next_readdata = {16'h0, ch4_counter};
    else if (avs_address_i == `CPWM_OFS_CH3_PER_CMP)
      next_readdata = {16'h0, ch3_period_compare};
    else if (avs_address_i == `CPWM_OFS_CH3_DUTY_CMP)
      next_readdata = {16'h0, ch3_duty_compare};
    else if (avs_address_i == `CPWM_OFS_CH3_PER_BUF)
      next_readdata = {16'h0, ch3_period_buffer};
    else if (avs_address_i == `CPWM_OFS_CH3_DUTY_BUF)
      next_readdata = {16'h0, ch3_duty_buffer};
    else if (avs_address_i == `CPWM_OFS_CH4_CMP_A)
      next_readdata = {16'h0, ch4_duty_compare_first};
    else if (avs_address_i == `CPWM_OFS_CH4_CMP_B)
      next_readdata = {16'h0, ch4_duty_compare_second};
    else if (avs_address_i == `CPWM_OFS_CH4_BUF_A)
      next_readdata = {16'h0, ch4_duty_buffer_first};
    else if (avs_address_i == `CPWM_OFS_CH4_BUF_B)
      next_readdata = {16'h0, ch4_duty_buffer_second};
    else if (avs_address_i == `CPWM_OFS_DEAD)
      next_readdata = {16'h0, dead_time_value};
    else if (avs_address_i == `CPWM_OFS_CYCLE)
      next_readdata = {16'h0, half_carrier_cycle};
    else if (avs_address_i == `CPWM_OFS_CYCLE_BUF)
      next_readdata = {16'h0, half_carrier_cycle_buffer};
    else if (avs_address_i == `CPWM_OFS_STATUS)
      next_readdata = {29'h0, cpwm_mode, ch4_down, ch3_down};
  end

  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i & ~ack)
      avs_readdata_o <= next_readdata;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ch3_timer_control    <= `CPWM_RST_CTRL;
      ch4_timer_control    <= `CPWM_RST_CTRL;
      ch3_mode             <= `CPWM_RST_CTRL;
      output_control_one   <= `CPWM_RST_CTRL;
      start_bits           <= 2'h0;
      standby_control_four <= `CPWM_RST_STANDBY;
    end
    else if (wr && avs_byteenable_i[0])
    begin
      if (avs_address_i == `CPWM_OFS_CH3_CTRL)
        ch3_timer_control <= wdata[7:0];
      else if (avs_address_i == `CPWM_OFS_CH4_CTRL)
        ch4_timer_control <= wdata[7:0];
      else if (avs_address_i == `CPWM_OFS_CH3_MODE)
        ch3_mode <= wdata[7:0];
      else if (avs_address_i == `CPWM_OFS_START)
        start_bits <= wdata[1:0];
      else if (avs_address_i == `CPWM_OFS_STANDBY)
        standby_control_four <= {wdata[31:8] & {24{avs_byteenable_i[2]}}, wdata[7:0]};
      else if (avs_address_i == `CPWM_OFS_OUT_CTRL)
      begin
        output_control_one[`CPWM_BIT_SYNC_EN] <= wdata[`CPWM_BIT_SYNC_EN];
        output_control_one[`CPWM_BIT_LOCK]    <= output_control_one[`CPWM_BIT_LOCK] | wdata[`CPWM_BIT_LOCK];
        if (!output_control_one[`CPWM_BIT_LOCK])
          output_control_one[2:0] <= wdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // compare, buffer and staging registers
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ch3_period_compare        <= 16'hffff;
      ch3_duty_compare          <= 16'h0000;
      ch3_period_buffer         <= 16'hffff;
      ch3_duty_buffer           <= 16'h0000;
      ch4_duty_compare_first    <= 16'h0000;
      ch4_duty_compare_second   <= 16'h0000;
      ch4_duty_buffer_first     <= 16'h0000;
      ch4_duty_buffer_second    <= 16'h0000;
      dead_time_value           <= 16'h0000;
      half_carrier_cycle        <= 16'hffff;
      half_carrier_cycle_buffer <= 16'hffff;
      stage_period              <= 16'hffff;
      stage_duty3               <= 16'h0000;
      stage_duty4a              <= 16'h0000;
      stage_duty4b              <= 16'h0000;
      stage_cycle               <= 16'hffff;
    end
    else
    begin
      // buffers copy into hidden staging on every clock cycle
      stage_period <= ch3_period_buffer;
      stage_duty3  <= ch3_duty_buffer;
      stage_duty4a <= ch4_duty_buffer_first;
      stage_duty4b <= ch4_duty_buffer_second;
      stage_cycle  <= half_carrier_cycle_buffer;
      if ((crest | trough) & cpwm_mode)
      begin
        ch3_period_compare      <= stage_period;
        ch3_duty_compare        <= stage_duty3;
        ch4_duty_compare_first  <= stage_duty4a;
        ch4_duty_compare_second <= stage_duty4b;
        half_carrier_cycle      <= stage_cycle;
      end
      if (wr && avs_byteenable_i[1:0] == 2'h3)
      begin
        if (avs_address_i == `CPWM_OFS_CH3_PER_CMP)
          ch3_period_compare <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH3_DUTY_CMP)
          ch3_duty_compare <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH3_PER_BUF)
          ch3_period_buffer <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH3_DUTY_BUF)
          ch3_duty_buffer <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH4_CMP_A)
          ch4_duty_compare_first <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH4_CMP_B)
          ch4_duty_compare_second <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH4_BUF_A)
          ch4_duty_buffer_first <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CH4_BUF_B)
          ch4_duty_buffer_second <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_DEAD)
          dead_time_value <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CYCLE)
          half_carrier_cycle <= wdata[15:0];
        else if (avs_address_i == `CPWM_OFS_CYCLE_BUF)
          half_carrier_cycle_buffer <= wdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ch3_counter <= 16'h0000;
      ch3_down    <= 1'b0;
    end
    else if (wr && avs_address_i == `CPWM_OFS_CH3_CNT && avs_byteenable_i[1:0] == 2'h3)
      ch3_counter <= wdata[15:0];
    else if (tick3)
    begin
      // counter clears at period compare only when a clear source is selected and complementary mode is off
      if (ch3_timer_control[7:`CPWM_CLR_LSB] != `CPWM_CLR_NONE && !cpwm_mode && ch3_counter == ch3_period_compare)
        ch3_counter <= 16'h0000;
      else if (!cpwm_mode)
        ch3_counter <= ch3_counter + 16'h0001;
      else if (!ch3_down && ch3_counter == ch3_period_compare)
      begin
        ch3_down    <= 1'b1;
        ch3_counter <= ch3_counter - 16'h0001;
      end
      else if (ch3_down && ch3_counter == dead_time_value)
      begin
        ch3_down    <= 1'b0;
        ch3_counter <= ch3_counter + 16'h0001;
      end
      else
        ch3_counter <= ch3_down ? ch3_counter - 16'h0001 : ch3_counter + 16'h0001;
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ch4_counter <= 16'h0000;
      ch4_down    <= 1'b0;
    end
    else if (wr && avs_address_i == `CPWM_OFS_CH4_CNT && avs_byteenable_i[1:0] == 2'h3)
      ch4_counter <= wdata[15:0];
    else if (tick4)
    begin
      if (ch4_timer_control[7:`CPWM_CLR_LSB] != `CPWM_CLR_NONE && !cpwm_mode && ch4_counter == half_carrier_cycle)
        ch4_counter <= 16'h0000;
      else if (!cpwm_mode)
        ch4_counter <= ch4_counter + 16'h0001;
      else if (!ch4_down && ch4_counter == half_carrier_cycle)
      begin
        ch4_down    <= 1'b1;
        ch4_counter <= ch4_counter - 16'h0001;
      end
      else if (ch4_down && ch4_counter == 16'h0000)
      begin
        ch4_down    <= 1'b0;
        ch4_counter <= 16'h0001;
      end
      else
        ch4_counter <= ch4_down ? ch4_counter - 16'h0001 : ch4_counter + 16'h0001;
    end
  end

  // ----------------------------------------
  // phase outputs
  // ----------------------------------------
  cpwm_phase u_phase_u
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .active_i  (cpwm_mode & run3),
    .cnt3_i    (ch3_counter),
    .cnt4_i    (ch4_counter),
    .cmp_i     (ch3_duty_compare),
    .dead_i    (dead_time_value),
    .lvl_p_i   (output_control_one[`CPWM_BIT_LVL_P]),
    .lvl_n_i   (output_control_one[`CPWM_BIT_LVL_N]),
    .pos_o     (pu_p),
    .neg_o     (pu_n)
  );
  cpwm_phase u_phase_v
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .active_i  (cpwm_mode & run3),
    .cnt3_i    (ch3_counter),
    .cnt4_i    (ch4_counter),
    .cmp_i     (ch4_duty_compare_first),
    .dead_i    (dead_time_value),
    .lvl_p_i   (output_control_one[`CPWM_BIT_LVL_P]),
    .lvl_n_i   (output_control_one[`CPWM_BIT_LVL_N]),
    .pos_o     (pv_p),
    .neg_o     (pv_n)
  );
  cpwm_phase u_phase_w
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .active_i  (cpwm_mode & run3),
    .cnt3_i    (ch3_counter),
    .cnt4_i    (ch4_counter),
    .cmp_i     (ch4_duty_compare_second),
    .dead_i    (dead_time_value),
    .lvl_p_i   (output_control_one[`CPWM_BIT_LVL_P]),
    .lvl_n_i   (output_control_one[`CPWM_BIT_LVL_N]),
    .pos_o     (pw_p),
    .neg_o     (pw_n)
  );

  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ch3_sync_toggle_output_o  <= 1'b0;
      phase_u_positive_output_o <= 1'b0;
      phase_u_negative_output_o <= 1'b0;
      phase_v_positive_output_o <= 1'b0;
      phase_v_negative_output_o <= 1'b0;
      phase_w_positive_output_o <= 1'b0;
      phase_w_negative_output_o <= 1'b0;
    end
    else
    begin
      if (output_control_one[`CPWM_BIT_SYNC_EN] && crest && cpwm_mode)
        ch3_sync_toggle_output_o <= ~ch3_sync_toggle_output_o;
      if (!output_control_one[`CPWM_BIT_SRC])
      begin
        phase_u_positive_output_o <= pu_p;
        phase_u_negative_output_o <= pu_n;
        phase_v_positive_output_o <= pv_p;
        phase_v_negative_output_o <= pv_n;
        phase_w_positive_output_o <= pw_p;
        phase_w_negative_output_o <= pw_n;
      end
    end
  end
endmodule // cpwm_timer

// File: sim/cpwm_timer_props.sv
// port checker for the complementary pwm timer
`timescale 1ns/1ps
module cpwm_props
(
  input wire        clk_sys_i,
  input wire        sys_rst_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        ch3_sync_toggle_output_o,
  input wire        phase_u_positive_output_o,
  input wire        phase_u_negative_output_o,
  input wire        phase_v_positive_output_o,
  input wire        phase_v_negative_output_o,
  input wire        phase_w_positive_output_o,
  input wire        phase_w_negative_output_o
);
  wire [6:0] pins = {ch3_sync_toggle_output_o, phase_u_positive_output_o, phase_u_negative_output_o,
                     phase_v_positive_output_o, phase_v_negative_output_o, phase_w_positive_output_o,
                     phase_w_negative_output_o};
  wire       req  = avs_read_i | avs_write_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // bus and output checks
  // ----------------------------------------
  reset_clears_a: assert property ($fell(sys_rst_i) |-> avs_waitrequest_o && avs_readdata_o == 32'h0 && pins == 7'h00)
    else $error("state not cleared by reset");
  req_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  wait_one_cycle_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  wait_needs_req_a: assert property (!avs_waitrequest_o |-> req && $past(req))
    else $error("answer without a request");
  rdata_hold_a: assert property (!$stable(avs_readdata_o) |-> !avs_waitrequest_o && $past(avs_read_i))
    else $error("read data changed outside a read");
  write_keeps_rdata_a: assert property (avs_write_i && !avs_waitrequest_o |=> $stable(avs_readdata_o))
    else $error("write disturbed read data");
  toggle_hold_a: assert property ($changed(ch3_sync_toggle_output_o) |=> $stable(ch3_sync_toggle_output_o)[*3])
    else $error("toggle output changed too soon");
  u_pulse_a: assert property ($changed(phase_u_positive_output_o) |=> $stable(phase_u_positive_output_o))
    else $error("phase u pulse of one cycle");
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property (avs_write_i && !avs_waitrequest_o);
  cover property ($changed(ch3_sync_toggle_output_o));
endmodule // cpwm_props

// File: sim/tb_top.sv
// self-checking bench for the complementary pwm timer
`timescale 1ns/1ps
`include "cpwm_map.vh"
module tb_top;
  reg         clk_sys_i;
  reg         sys_rst_i;
  reg  [7:0]  avs_address_i;
  reg         avs_read_i;
  reg         avs_write_i;
  reg  [31:0] avs_writedata_i;
  reg  [3:0]  avs_byteenable_i;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o;
  wire [6:0]  pin;
  reg  [6:0]  pin_q;
  reg  [31:0] q;
  reg  [31:0] q2;
  integer     bad_count;
  integer     checks;
  integer     edges [0:6];
  integer     i;
  integer     j;
  integer     dn3;
  integer     dn4;
  cpwm_timer DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ch3_sync_toggle_output_o(pin[6]), .phase_u_positive_output_o(pin[5]), .phase_u_negative_output_o(pin[4]),
    .phase_v_positive_output_o(pin[3]), .phase_v_negative_output_o(pin[2]),
    .phase_w_positive_output_o(pin[1]), .phase_w_negative_output_o(pin[0]));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    pin_q <= pin;
    for (j = 0; j < 7; j = j + 1)
      if (pin[j] !== pin_q[j] && !sys_rst_i)
        edges[j] = edges[j] + 1;
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    integer n;
  begin
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= d;
    n = 0;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n == 20)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: bus timeout", $time);
      test_done;
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task chk(input [7:0] a, input [31:0] e);
  begin
    bus(a, 1'b0, 32'h0);
    cmp(q, e);
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    sys_rst_i        = 1'b1;
    avs_address_i    = 8'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hf;
    pin_q            = 7'h00;
    bad_count        = 0;
    checks           = 0;
    dn3              = 0;
    dn4              = 0;
    for (i = 0; i < 7; i = i + 1)
      edges[i] = 0;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    chk(`CPWM_OFS_CH3_CTRL, {24'h0, `CPWM_RST_CTRL});
    chk(`CPWM_OFS_STANDBY, `CPWM_RST_STANDBY);
    chk(8'hfc, 32'h0);
    for (i = 0; i < 13; i = i + 1)
    begin
      wr(8'h18 + {i[5:0], 2'b00}, {16'hdead, 16'h0a50 + i[15:0]});
      chk(8'h18 + {i[5:0], 2'b00}, {16'h0000, 16'h0a50 + i[15:0]});
    end
    wr(`CPWM_OFS_CH3_CTRL, {24'h0, `CPWM_CLR_NONE, `CPWM_EDGE_RISE, `CPWM_PSC_DIV4});
    wr(`CPWM_OFS_CH4_CTRL, {24'h0, `CPWM_CLR_NONE, `CPWM_EDGE_RISE, `CPWM_PSC_DIV4});
    wr(`CPWM_OFS_CH3_MODE, {28'h0, `CPWM_MODE_CPWM3});
    wr(`CPWM_OFS_DEAD, 32'h4);
    wr(`CPWM_OFS_CYCLE, 32'h14);
    wr(`CPWM_OFS_CYCLE_BUF, 32'h14);
    wr(`CPWM_OFS_CH3_PER_CMP, 32'h18);
    wr(`CPWM_OFS_CH3_PER_BUF, 32'h18);
    wr(`CPWM_OFS_CH3_DUTY_CMP, 32'ha);
    wr(`CPWM_OFS_CH3_DUTY_BUF, 32'ha);
    wr(`CPWM_OFS_CH4_CMP_A, 32'h8);
    wr(`CPWM_OFS_CH4_BUF_A, 32'h8);
    wr(`CPWM_OFS_CH4_CMP_B, 32'he);
    wr(`CPWM_OFS_CH4_BUF_B, 32'he);
    wr(`CPWM_OFS_CH3_CNT, 32'h4);
    wr(`CPWM_OFS_CH4_CNT, 32'h0);
    wr(`CPWM_OFS_OUT_CTRL, 32'h40);
    wr(`CPWM_OFS_START, 32'h3);
    repeat (20) @(posedge clk_sys_i);
    chk(`CPWM_OFS_CH3_CNT, 32'h4);
    bus(`CPWM_OFS_STATUS, 1'b0, 32'h0);
    cmp({31'h0, q[2]}, 32'h1);
    wr(`CPWM_OFS_STANDBY, 32'h0);
    bus(`CPWM_OFS_CH3_CNT, 1'b0, 32'h0);
    q2 = q;
    repeat (37) @(posedge clk_sys_i);
    bus(`CPWM_OFS_CH3_CNT, 1'b0, 32'h0);
    cmp({31'h0, q - q2 >= 32'h9 && q - q2 <= 32'hb}, 32'h1);
    wr(`CPWM_OFS_CYCLE_BUF, 32'h10);
    wr(`CPWM_OFS_CH3_PER_BUF, 32'h14);
    wr(`CPWM_OFS_CH3_DUTY_BUF, 32'hc);
    for (i = 0; i < 60; i = i + 1)
    begin
      bus(`CPWM_OFS_CH3_CNT, 1'b0, 32'h0);
      cmp({31'h0, q >= 32'h4 && q <= 32'h18}, 32'h1);
      bus(`CPWM_OFS_CH4_CNT, 1'b0, 32'h0);
      cmp({31'h0, q <= 32'h14}, 32'h1);
      bus(`CPWM_OFS_STATUS, 1'b0, 32'h0);
      dn3 = dn3 + q[0];
      dn4 = dn4 + q[1];
    end
    cmp({31'h0, dn3 > 0 && dn3 < 60 && dn4 > 0 && dn4 < 60}, 32'h1);
    chk(`CPWM_OFS_CYCLE, 32'h10);
    chk(`CPWM_OFS_CH3_PER_CMP, 32'h14);
    chk(`CPWM_OFS_CH3_DUTY_CMP, 32'hc);
    cmp({31'h0, edges[6] >= 2}, 32'h1);
    cmp({31'h0, edges[5] >= 2 && edges[3] >= 2 && edges[1] >= 2}, 32'h1);
    cmp({31'h0, edges[4] >= 2 && edges[2] >= 2 && edges[0] >= 2}, 32'h1);
    wr(`CPWM_OFS_CH3_CTRL, {24'h0, `CPWM_CLR_NONE, 2'h1, `CPWM_PSC_DIV4});
    wr(`CPWM_OFS_CH4_CTRL, {24'h0, `CPWM_CLR_NONE, 2'h1, `CPWM_PSC_DIV4});
    wr(`CPWM_OFS_OUT_CTRL, 32'h40);
    repeat (2) @(posedge clk_sys_i);
    q2 = {25'h0, pin};
    wr(`CPWM_OFS_OUT_CTRL, 32'h43);
    repeat (2) @(posedge clk_sys_i);
    cmp({30'h0, pin[5:4]}, {30'h0, ~q2[5:4]});
    chk(`CPWM_OFS_OUT_CTRL, 32'h43);
    wr(`CPWM_OFS_OUT_CTRL, 32'h4b);
    wr(`CPWM_OFS_OUT_CTRL, 32'h48);
    chk(`CPWM_OFS_OUT_CTRL, 32'h4b);
    test_done;
  end
endmodule // tb_top
bind cpwm_timer cpwm_props chk_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .ch3_sync_toggle_output_o(ch3_sync_toggle_output_o), .phase_u_positive_output_o(phase_u_positive_output_o),
  .phase_u_negative_output_o(phase_u_negative_output_o), .phase_v_positive_output_o(phase_v_positive_output_o),
  .phase_v_negative_output_o(phase_v_negative_output_o), .phase_w_positive_output_o(phase_w_positive_output_o),
  .phase_w_negative_output_o(phase_w_negative_output_o));
